// File: src/rsafr_fifo.sv
// Purpose: Circular byte buffer between receiver and host.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Write when full is dropped; the caller flags it.
`timescale 1ns/1ps
module rsafr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic                       i_mclk,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_clear,
	input  wire logic                       i_in_valid,
	input  wire logic [WIDTH-1:0]           i_in_data,
	output logic                            o_in_ready,
	output logic                            o_out_valid,
	output logic [WIDTH-1:0]                o_out_data,
	input  wire logic                       i_out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               cnt;
		logic                        full;
		logic                        has;
		logic                        rdy;
		logic [WIDTH-1:0]            head;
	} rsafr_fifo_st_t;
	rsafr_fifo_st_t r_reg;
	rsafr_fifo_st_t r_next;
	logic push;
	logic pop;

	always_comb begin
		r_next = r_reg;
		push = i_in_valid & r_reg.rdy;
		pop = i_out_ready & r_reg.has;
		if (push) begin
			r_next.mem[r_reg.wp] = i_in_data;
			r_next.wp = (r_reg.wp == PW'(DEPTH-1)) ? '0 : r_reg.wp + 1'b1; // R19
		end
		if (pop) begin
			r_next.rp = (r_reg.rp == PW'(DEPTH-1)) ? '0 : r_reg.rp + 1'b1; // R19
		end
		if (push && !pop) begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
		if (i_clear) begin
			r_next.wp = '0;
			r_next.rp = '0;
			r_next.cnt = '0;
		end
		r_next.full = (r_next.cnt == CW'(DEPTH));
		r_next.has = (r_next.cnt != '0);
		// Ready and head word are registered so the ports leave a flip-flop.
		r_next.rdy = ~r_next.full;
		r_next.head = r_next.mem[r_next.rp];
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			r_reg <= '0;
			r_reg.rdy <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_in_ready = r_reg.rdy;
	assign o_out_valid = r_reg.has;
	assign o_out_data = r_reg.head;
	assign o_count = r_reg.cnt;

	a_fifo_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R19
		r_reg.cnt <= CW'(DEPTH) && (r_reg.full == (r_reg.cnt == CW'(DEPTH))))
		else $error("Fifo count beyond depth.");
	a_fifo_push_step: assert property (@(posedge i_mclk) // R18
		disable iff (!i_rst_n)
		(push && !pop && !i_clear) |=> r_reg.cnt == $past(r_reg.cnt) + 1'b1)
		else $error("Fifo count did not follow a push.");
endmodule

// File: src/rsafr_pkg.sv
// Purpose: Shared constants and state type of the reader register bank.
// Assumes: 100 MHz i_mclk.
// Notes:   Offsets are register port addresses.
package rsafr_pkg;
	localparam logic [4:0] ADDR_MAIN  = 5'h16;
	localparam logic [4:0] ADDR_AUX   = 5'h17;
	localparam logic [4:0] ADDR_SETP  = 5'h18;
	localparam logic [4:0] ADDR_CONV  = 5'h19;
	localparam logic [4:0] ADDR_LENH  = 5'h1A;
	localparam logic [4:0] ADDR_LENL  = 5'h1B;
	localparam logic [4:0] ADDR_FSTAT = 5'h1C;
	localparam logic [23:0] MAIN_RST  = 24'h40D84F;
	localparam logic [23:0] AUX_RST   = 24'h011846;
	localparam logic [7:0]  SETP_RST  = 8'h00;
	localparam logic [7:0]  LEN_RST   = 8'h00;
	localparam logic [7:0]  LENH_MASK = 8'hC3;
	localparam int BIAS_BIT   = 23;
	localparam int REF_HI     = 22;
	localparam int REF_LO     = 20;
	localparam int OSC_BIT    = 22;
	localparam int EXT_BIT    = 21;
	localparam int PRESC_BIT  = 20;
	localparam int B_HI       = 19;
	localparam int B_LO       = 10;
	localparam int A_HI       = 9;
	localparam int A_LO       = 0;
	localparam int SKIP_BIT   = 7;
	localparam int RAW_BIT    = 6;
	localparam int LEN_HI_TOP = 1;
	localparam logic [7:0] CMD_MAIN = 8'h84;
	localparam logic [7:0] CMD_AUX  = 8'h85;
	localparam logic [7:0] CMD_ADC  = 8'h87;
	localparam logic [7:0] CMD_FRST = 8'h8F;
	localparam logic [2:0] MSEL_MIX_A = 3'h1;
	localparam logic [2:0] MSEL_MIX_B = 3'h2;
	localparam logic [2:0] MSEL_EXT   = 3'h3;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS  = 20000;
	localparam logic [11:0] CONV_CYCLES =
		12'(CONV_TIME_NS / CLK_PERIOD_NS);
	localparam int FIFO_DEPTH = 24;
	localparam int FIFO_WIDTH = 8;
	localparam logic [4:0] FIFO_HI_LEVEL = 5'h12;
	localparam logic [4:0] FIFO_LO_LEVEL = 5'h06;

	typedef struct packed {
		logic [2:0]  en_sync;
		logic        en_ok;
		logic [23:0] main_div;
		logic [23:0] aux_div;
		logic [7:0]  setp;
		logic [7:0]  conv;
		logic [7:0]  len_hi;
		logic [7:0]  len_lo;
		logic        use_aux;
		logic        conv_busy;
		logic [11:0] conv_cnt;
		logic        ovf;
		logic [23:0] rdata;
		logic [8:0]  ref_khz;
		logic [9:0]  div_b;
		logic [9:0]  div_a;
		logic [16:0] div_n;
		logic        irq_hdr;
		logic        third_error_interrupt;
	} rsafr_st_t;
endpackage

// File: src/rsafr_top.sv
// Purpose: Synthesizer, converter, receive length and fifo registers.
// Assumes: Register port gives address, write and read strobes.
// Notes:   i_en is a pin and passes a three-stage synchroniser.
//
// What this block does
// [R1] Bit 23 doubles or quadruples bias.
// [R2] Main bits 22:20 select reference frequency.
// [R3] B and A give N=B*32+A*33.
// [R4] Main divider presets to 40D84F.
// [R5] Auxiliary divider presets to 011846.
// [R6] Aux bit 22 selects direct oscillator.
// [R7] Aux bit 21 selects external RF input.
// [R8] Aux bit 20 enables divider and prescaler.
// [R9] Setpoint register clears to 00.
// [R10] Command 87 converts; result within 20us.
// [R11] Source select picks the converter input.
// [R12] Length bit 7 skips next CRC check.
// [R13] Length bit 6 remaps fifo and interrupts.
// [R14] Ten-bit length clears at reception end.
// [R15] High flag at 18 bytes during reception.
// [R16] Low flag at 6 bytes during transmission.
// [R17] Overflow flag on write into full fifo.
// [R18] Low five status bits count fifo bytes.
// [R19] Fifo is 24 bytes, circular order.
// [R20] Commands 84 and 85 pick divider register.
// [R21] Source codes 001, 010 mixers, 011 pin.
// [R22] Result and status ignore host writes.
`timescale 1ns/1ps
module rsafr_top (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_en,
	input  wire logic [4:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [23:0] i_reg_wdata,
	output logic      [23:0] o_reg_rdata,
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [2:0]  i_meas_select,
	input  wire logic [7:0]  i_mixer_a_level,
	input  wire logic [7:0]  i_mixer_b_level,
	input  wire logic [7:0]  i_ext_conv_level,
	input  wire logic        i_rx_active,
	input  wire logic        i_tx_active,
	input  wire logic        i_rx_end,
	input  wire logic        i_header_evt,
	input  wire logic        i_second_byte_evt,
	input  wire logic        i_err3_evt,
	input  wire logic        i_rx_done_evt,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_data,
	output logic             o_rx_ready,
	output logic             o_fifo_valid,
	output logic      [7:0]  o_fifo_data,
	input  wire logic        i_fifo_ready,
	output logic             o_bias_double,
	output logic             o_bias_quadruple,
	output logic      [2:0]  o_reference_divider_select,
	output logic      [8:0]  o_ref_khz,
	output logic      [9:0]  o_div_b,
	output logic      [9:0]  o_div_a,
	output logic      [16:0] o_div_n,
	output logic             o_use_aux,
	output logic             o_osc_direct,
	output logic             o_external_rf_input_pin_sel,
	output logic             o_presc_enable,
	output logic      [7:0]  o_setpoint,
	output logic             o_conv_busy,
	output logic             o_skip_crc_once,
	output logic             o_raw_fifo_second_byte_irq,
	output logic      [9:0]  o_rx_length,
	output logic             o_irq_header,
	output logic             o_third_error_interrupt
);
	rsafr_pkg::rsafr_st_t r_reg;
	rsafr_pkg::rsafr_st_t r_next;
	logic        fifo_clear;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	logic [4:0]  fifo_count;
	logic        fifo_hi;
	logic        fifo_lo;
	logic [7:0]  fifo_status;
	logic [7:0]  sample;
	logic [23:0] sel_div;
	logic        adc_cmd;

	// The fifo stays empty while the device is disabled.
	assign fifo_clear = ~r_reg.en_ok
		| (i_cmd_valid & (i_cmd_code == rsafr_pkg::CMD_FRST));

	rsafr_fifo #(
		.WIDTH (rsafr_pkg::FIFO_WIDTH),
		.DEPTH (rsafr_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_rst_n     (i_rst_n),
		.i_clear     (fifo_clear),
		.i_in_valid  (i_rx_valid),
		.i_in_data   (i_rx_data),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (i_fifo_ready),
		.o_count     (fifo_count)
	);

	always_comb begin
		r_next = r_reg;
		sample = 8'h00;
		sel_div = 24'h000000;
		adc_cmd = 1'b0;
		fifo_hi = i_rx_active
			& (fifo_count >= rsafr_pkg::FIFO_HI_LEVEL); // R15
		fifo_lo = i_tx_active
			& (fifo_count <= rsafr_pkg::FIFO_LO_LEVEL); // R16
		fifo_status = {fifo_hi, fifo_lo, r_reg.ovf, fifo_count}; // R18

		// Only the second and third stages are compared.
		r_next.en_sync = {r_reg.en_sync[1:0], i_en};
		if (r_reg.en_sync[2] == r_reg.en_sync[1]) begin
			r_next.en_ok = r_reg.en_sync[2];
		end

		if (i_rx_end) begin
			r_next.len_hi = rsafr_pkg::LEN_RST; // R14
			r_next.len_lo = rsafr_pkg::LEN_RST; // R14
		end

		// A host write in the end-of-reception cycle wins.
		if (i_reg_wr) begin
			case (i_reg_addr)
				rsafr_pkg::ADDR_MAIN: begin
					r_next.main_div = i_reg_wdata;
				end
				rsafr_pkg::ADDR_AUX: begin
					r_next.aux_div = i_reg_wdata;
				end
				rsafr_pkg::ADDR_SETP: begin
					r_next.setp = i_reg_wdata[7:0];
				end
				rsafr_pkg::ADDR_LENH: begin
					r_next.len_hi = i_reg_wdata[7:0]
						& rsafr_pkg::LENH_MASK;
				end
				rsafr_pkg::ADDR_LENL: begin
					r_next.len_lo = i_reg_wdata[7:0];
				end
				default: begin
					r_next.rdata = r_next.rdata; // R22
				end
			endcase
		end

		case (i_meas_select)
			rsafr_pkg::MSEL_MIX_A: begin
				sample = i_mixer_a_level; // R21
			end
			rsafr_pkg::MSEL_MIX_B: begin
				sample = i_mixer_b_level; // R21
			end
			rsafr_pkg::MSEL_EXT: begin
				sample = i_ext_conv_level; // R11
			end
			default: begin
				sample = 8'h00;
			end
		endcase

		// The source is taken at the end, so it must not move mid-way.
		if (r_reg.conv_busy) begin
			r_next.conv_cnt = r_reg.conv_cnt - 12'h001;
			if (r_reg.conv_cnt == 12'h000) begin
				r_next.conv_busy = 1'b0;
				r_next.conv = sample; // R10
			end
		end

		if (i_cmd_valid) begin
			case (i_cmd_code)
				rsafr_pkg::CMD_MAIN: begin
					r_next.use_aux = 1'b0; // R20
				end
				rsafr_pkg::CMD_AUX: begin
					r_next.use_aux = 1'b1; // R20
				end
				rsafr_pkg::CMD_ADC: begin
					adc_cmd = 1'b1;
					r_next.conv_busy = 1'b1; // R10
					r_next.conv_cnt = rsafr_pkg::CONV_CYCLES - 12'h001;
				end
				default: begin
					adc_cmd = 1'b0;
				end
			endcase
		end

		// Set wins over the flush so no overrun is lost.
		r_next.ovf = (i_rx_valid & ~fifo_in_ready)
			| (r_reg.ovf & ~fifo_clear); // R17

		if (!r_reg.en_ok) begin
			r_next.main_div = rsafr_pkg::MAIN_RST; // R4
			r_next.aux_div = rsafr_pkg::AUX_RST; // R5
			r_next.setp = rsafr_pkg::SETP_RST; // R9
			r_next.len_hi = rsafr_pkg::LEN_RST; // R14
			r_next.len_lo = rsafr_pkg::LEN_RST; // R14
			r_next.use_aux = 1'b0;
			r_next.conv_busy = 1'b0;
			r_next.conv_cnt = 12'h000;
		end

		if (i_reg_rd) begin
			case (i_reg_addr)
				rsafr_pkg::ADDR_MAIN: begin
					r_next.rdata = r_reg.main_div;
				end
				rsafr_pkg::ADDR_AUX: begin
					r_next.rdata = r_reg.aux_div;
				end
				rsafr_pkg::ADDR_SETP: begin
					r_next.rdata = {16'h0000, r_reg.setp};
				end
				rsafr_pkg::ADDR_CONV: begin
					r_next.rdata = {16'h0000, r_reg.conv};
				end
				rsafr_pkg::ADDR_LENH: begin
					r_next.rdata = {16'h0000, r_reg.len_hi};
				end
				rsafr_pkg::ADDR_LENL: begin
					r_next.rdata = {16'h0000, r_reg.len_lo};
				end
				rsafr_pkg::ADDR_FSTAT: begin
					r_next.rdata = {16'h0000, fifo_status};
				end
				default: begin
					r_next.rdata = 24'h000000;
				end
			endcase
		end

		sel_div = r_next.use_aux ? r_next.aux_div : r_next.main_div; // R20
		r_next.div_b = sel_div[rsafr_pkg::B_HI:rsafr_pkg::B_LO]; // R3
		r_next.div_a = sel_div[rsafr_pkg::A_HI:rsafr_pkg::A_LO]; // R3
		r_next.div_n = 17'(r_next.div_b) * 17'h00020
			+ 17'(r_next.div_a) * 17'h00021; // R3

		case (r_next.main_div[rsafr_pkg::REF_HI:rsafr_pkg::REF_LO])
			3'h0: r_next.ref_khz = 9'h1F4; // R2
			3'h1: r_next.ref_khz = 9'h0FA; // R2
			3'h4: r_next.ref_khz = 9'h0C8; // R2
			3'h2: r_next.ref_khz = 9'h07D; // R2
			3'h5: r_next.ref_khz = 9'h064; // R2
			3'h6: r_next.ref_khz = 9'h032; // R2
			3'h7: r_next.ref_khz = 9'h019; // R2
			default: r_next.ref_khz = 9'h000;
		endcase

		// Interrupt meaning follows the mode bit as it stands now.
		if (r_reg.len_hi[rsafr_pkg::RAW_BIT]) begin
			r_next.irq_hdr = i_second_byte_evt; // R13
			r_next.third_error_interrupt = i_rx_done_evt; // R13
		end else begin
			r_next.irq_hdr = i_header_evt;
			r_next.third_error_interrupt = i_err3_evt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			r_reg <= '0;
			r_reg.main_div <= rsafr_pkg::MAIN_RST; // R4
			r_reg.aux_div <= rsafr_pkg::AUX_RST; // R5
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_reg_rdata = r_reg.rdata;
	assign o_rx_ready = fifo_in_ready;
	assign o_fifo_valid = fifo_out_valid;
	assign o_fifo_data = fifo_out_data;
	assign o_bias_double = r_reg.main_div[rsafr_pkg::BIAS_BIT]; // R1
	assign o_bias_quadruple = r_reg.aux_div[rsafr_pkg::BIAS_BIT]; // R1
	assign o_reference_divider_select =
		r_reg.main_div[rsafr_pkg::REF_HI:rsafr_pkg::REF_LO]; // R2
	assign o_ref_khz = r_reg.ref_khz;
	assign o_div_b = r_reg.div_b;
	assign o_div_a = r_reg.div_a;
	assign o_div_n = r_reg.div_n;
	assign o_use_aux = r_reg.use_aux;
	assign o_osc_direct = r_reg.aux_div[rsafr_pkg::OSC_BIT]; // R6
	assign o_external_rf_input_pin_sel =
		r_reg.aux_div[rsafr_pkg::EXT_BIT]; // R7
	assign o_presc_enable = r_reg.aux_div[rsafr_pkg::PRESC_BIT]; // R8
	assign o_setpoint = r_reg.setp; // R9
	assign o_conv_busy = r_reg.conv_busy;
	// Cleared at reception end, so it lasts one reception.
	assign o_skip_crc_once = r_reg.len_hi[rsafr_pkg::SKIP_BIT]; // R12
	assign o_raw_fifo_second_byte_irq =
		r_reg.len_hi[rsafr_pkg::RAW_BIT]; // R13
	assign o_rx_length = {r_reg.len_hi[rsafr_pkg::LEN_HI_TOP:0],
		r_reg.len_lo}; // R14
	assign o_irq_header = r_reg.irq_hdr;
	assign o_third_error_interrupt = r_reg.third_error_interrupt;

	a_main_preset: assert property (@(posedge i_mclk) // R4
		disable iff (!i_rst_n)
		!r_reg.en_ok |=> r_reg.main_div == rsafr_pkg::MAIN_RST)
		else $error("Main divider not preset.");
	a_aux_preset: assert property (@(posedge i_mclk) // R5
		disable iff (!i_rst_n)
		!r_reg.en_ok |=> r_reg.aux_div == rsafr_pkg::AUX_RST)
		else $error("Auxiliary divider not preset.");
	a_setp_clear: assert property (@(posedge i_mclk) // R9
		disable iff (!i_rst_n)
		!r_reg.en_ok |=> r_reg.setp == 8'h00)
		else $error("Setpoint not cleared.");
	a_len_end_clear: assert property (@(posedge i_mclk) // R14
		disable iff (!i_rst_n)
		(i_rx_end && !i_reg_wr) |=> o_rx_length == 10'h000
			&& !o_skip_crc_once)
		else $error("Receive length not cleared.");
	a_conv_start: assert property (@(posedge i_mclk) // R10
		disable iff (!i_rst_n)
		(adc_cmd && r_reg.en_ok) |=> r_reg.conv_busy
			&& r_reg.conv_cnt == rsafr_pkg::CONV_CYCLES - 12'h001)
		else $error("Conversion did not start.");
	a_conv_finish: assert property (@(posedge i_mclk) // R10
		disable iff (!i_rst_n)
		(r_reg.conv_busy && r_reg.conv_cnt == 12'h000 && !adc_cmd
			&& r_reg.en_ok)
		|=> !r_reg.conv_busy && r_reg.conv == $past(sample))
		else $error("Conversion result not loaded on time.");
	a_result_ro: assert property (@(posedge i_mclk) // R22
		disable iff (!i_rst_n)
		(i_reg_wr && i_reg_addr == rsafr_pkg::ADDR_CONV
			&& !r_reg.conv_busy) |=> $stable(r_reg.conv))
		else $error("Write changed the conversion result.");
	a_aux_hop: assert property (@(posedge i_mclk) // R20
		disable iff (!i_rst_n)
		(i_cmd_valid && i_cmd_code == rsafr_pkg::CMD_AUX
			&& r_reg.en_ok) |=> o_use_aux
			&& o_div_b == r_reg.aux_div[rsafr_pkg::B_HI:rsafr_pkg::B_LO])
		else $error("Hop to auxiliary divider failed.");
	a_total_div: assert property (@(posedge i_mclk) // R3
		disable iff (!i_rst_n)
		o_div_n == 17'(o_div_b) * 17'h00020 + 17'(o_div_a) * 17'h00021
			&& (!$past(i_rst_n)
			|| {o_div_b, o_div_a} == (o_use_aux
			? r_reg.aux_div[rsafr_pkg::B_HI:rsafr_pkg::A_LO]
			: r_reg.main_div[rsafr_pkg::B_HI:rsafr_pkg::A_LO])))
		else $error("Total division wrong.");
	a_ovf_set: assert property (@(posedge i_mclk) // R17
		disable iff (!i_rst_n)
		(i_rx_valid && !fifo_in_ready)
		|=> r_reg.ovf ##1 (r_reg.ovf || $past(fifo_clear)))
		else $error("Overflow flag missed or dropped.");
endmodule

// File: tb/rsafr_host.sv
// Purpose: Host model driving the register port and the command port.
// Assumes: Strobes change 1 ns after the rising edge of i_mclk.
// Notes:   Idle write data shows the inverse of its last value.
`timescale 1ns/1ps
module rsafr_host (
	input  wire logic        i_mclk,
	output logic      [4:0]  o_addr,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [23:0] o_wdata,
	input  wire logic [23:0] i_rdata,
	output logic             o_cmd_valid,
	output logic      [7:0]  o_cmd_code
);
	initial begin
		o_addr = 5'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 24'h000000;
		o_cmd_valid = 1'b0;
		o_cmd_code = 8'h00;
	end

	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		@(posedge i_mclk);
		#1;
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_mclk);
		#1;
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask

	task automatic rd(input logic [4:0] a, output logic [23:0] d);
		@(posedge i_mclk);
		#1;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_mclk);
		#1;
		o_rd = 1'b0;
		d = i_rdata;
	endtask

	task automatic cmd(input logic [7:0] c);
		@(posedge i_mclk);
		#1;
		o_cmd_code = c;
		o_cmd_valid = 1'b1;
		@(posedge i_mclk);
		#1;
		o_cmd_valid = 1'b0;
		o_cmd_code = ~c;
	endtask

	// Reading earlier would return a stale result, so the host waits out
	// the full conversion time counted from the trigger edge.
	task automatic wait_conv();
		repeat (2000) @(posedge i_mclk);
		#1;
	endtask
endmodule

// File: tb/rsafr_top_tb_top.sv
// Purpose: Self-checking bench of the reader register bank.
// Assumes: Expected values come from a queue and array model here.
// Notes:   Conversions dominate the run time, about 2000 cycles each.
`timescale 1ns/1ps
module rsafr_top_tb_top;
	logic        i_mclk, i_rst_n, i_en, i_reg_wr, i_reg_rd, i_cmd_valid;
	logic [4:0]  i_reg_addr;
	logic [23:0] i_reg_wdata, o_reg_rdata, d;
	logic [7:0]  i_cmd_code, i_mixer_a_level, i_mixer_b_level;
	logic [7:0]  i_ext_conv_level, i_rx_data, o_fifo_data, o_setpoint;
	logic [2:0]  i_meas_select, o_reference_divider_select;
	logic        i_rx_active, i_tx_active, i_rx_end, i_header_evt;
	logic        i_second_byte_evt, i_err3_evt, i_rx_done_evt, i_rx_valid;
	logic        o_rx_ready, o_fifo_valid, i_fifo_ready, o_bias_double;
	logic        o_bias_quadruple, o_use_aux, o_osc_direct, o_presc_enable;
	logic        o_external_rf_input_pin_sel, o_conv_busy, o_skip_crc_once;
	logic        o_raw_fifo_second_byte_irq, o_irq_header;
	logic        o_third_error_interrupt, ovf, aux_sel;
	logic [8:0]  o_ref_khz;
	logic [9:0]  o_div_b, o_div_a, o_rx_length;
	logic [16:0] o_div_n;
	logic [23:0] m [32];
	logic [7:0]  lv [4];
	logic [7:0]  q [$];
	int          n_fail, tests_run, cyc;
	int          khz [8] = '{500, 250, 125, 0, 200, 100, 50, 25};

	rsafr_top DUT (
		.i_mclk, .i_rst_n, .i_en, .i_reg_addr, .i_reg_wr, .i_reg_rd,
		.i_reg_wdata, .o_reg_rdata, .i_cmd_valid, .i_cmd_code,
		.i_meas_select, .i_mixer_a_level, .i_mixer_b_level,
		.i_ext_conv_level, .i_rx_active, .i_tx_active, .i_rx_end,
		.i_header_evt, .i_second_byte_evt, .i_err3_evt, .i_rx_done_evt,
		.i_rx_valid, .i_rx_data, .o_rx_ready, .o_fifo_valid, .o_fifo_data,
		.i_fifo_ready, .o_bias_double, .o_bias_quadruple,
		.o_reference_divider_select, .o_ref_khz, .o_div_b, .o_div_a,
		.o_div_n, .o_use_aux, .o_osc_direct, .o_external_rf_input_pin_sel,
		.o_presc_enable, .o_setpoint, .o_conv_busy, .o_skip_crc_once,
		.o_raw_fifo_second_byte_irq, .o_rx_length, .o_irq_header,
		.o_third_error_interrupt
	);

	rsafr_host host (
		.i_mclk, .o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
		.o_wdata(i_reg_wdata), .i_rdata(o_reg_rdata),
		.o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code)
	);

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic preset();
		foreach (m[i]) if (i != 25) m[i] = 24'h000000;
		m[22] = 24'h40D84F;
		m[23] = 24'h011846;
		q.delete();
		ovf = 1'b0;
		aux_sel = 1'b0;
	endtask

	function automatic logic [23:0] stat(input logic rx, input logic tx);
		int n;
		n = q.size();
		return {16'h0000, rx && n >= 18, tx && n <= 6, ovf, 5'(n)};
	endfunction

	task automatic wm(input logic [4:0] a, input logic [23:0] v);
		host.wr(a, v);
		if (a == 5'h16 || a == 5'h17) m[a] = v;
		else if (a == 5'h1A) m[a] = {16'h0000, v[7:0] & 8'hC3};
		else if (a == 5'h18 || a == 5'h1B) m[a] = {16'h0000, v[7:0]};
	endtask

	task automatic rc(input logic [4:0] a);
		logic [23:0] v;
		if (a == 5'h1C) m[a] = stat(i_rx_active, i_tx_active);
		host.rd(a, v);
		chk(v, m[a]);
	endtask

	task automatic chk_syn();
		logic [23:0] s;
		s = aux_sel ? m[23] : m[22];
		chk(o_div_b, s[19:10]);
		chk(o_div_a, s[9:0]);
		chk(o_div_n, s[19:10] * 32 + s[9:0] * 33);
		chk(o_use_aux, aux_sel);
		chk({o_bias_double, o_reference_divider_select}, m[22][23:20]);
		chk(o_ref_khz, 24'(khz[m[22][22:20]]));
		chk({o_bias_quadruple, o_osc_direct, o_external_rf_input_pin_sel,
			o_presc_enable}, m[23][23:20]);
		chk(o_setpoint, m[24][7:0]);
		chk({o_skip_crc_once, o_raw_fifo_second_byte_irq}, m[26][7:6]);
		chk(o_rx_length, {m[26][1:0], m[27][7:0]});
	endtask

	// The push is offered even when the buffer shows full, on purpose.
	task automatic push(input int n);
		logic rdy;
		@(posedge i_mclk);
		#1;
		for (int i = 0; i < n; i++) begin
			rdy = (q.size() < rsafr_pkg::FIFO_DEPTH);
			chk(o_rx_ready, rdy);
			i_rx_valid = 1'b1;
			i_rx_data = 8'($urandom);
			@(posedge i_mclk);
			if (rdy) q.push_back(i_rx_data);
			else ovf = 1'b1;
			#1;
		end
		i_rx_valid = 1'b0;
		i_rx_data = ~i_rx_data;
	endtask

	task automatic drain(input int n);
		logic rdy;
		@(posedge i_mclk);
		#1;
		for (int g = 0; g < 300 && q.size() > n; g++) begin
			rdy = 1'($urandom);
			i_fifo_ready = rdy;
			chk(o_fifo_valid, 1'b1);
			if (rdy) chk(o_fifo_data, q.pop_front());
			@(posedge i_mclk);
			#1;
		end
		i_fifo_ready = 1'b0;
		chk(24'(q.size()), 24'(n));
	endtask

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	initial begin
		cyc = 0;
		forever begin
			@(posedge i_mclk);
			cyc++;
			if (cyc == 20000) begin
				n_fail++;
				complete_run();
			end
		end
	end

	initial begin
		{i_rst_n, i_rx_active, i_tx_active, i_rx_end, i_rx_valid} = 5'h00;
		{i_header_evt, i_second_byte_evt, i_err3_evt, i_rx_done_evt} = 4'h0;
		{i_fifo_ready, i_meas_select, i_rx_data} = 12'h000;
		{i_mixer_a_level, i_mixer_b_level, i_ext_conv_level} = 24'h000000;
		i_en = 1'b1;
		n_fail = 0;
		tests_run = 0;
		m[25] = 24'h000000;
		preset();
		void'($urandom(32'hEE77));
		repeat (3) @(posedge i_mclk);
		#1;
		i_rst_n = 1'b1;
		repeat (4) @(posedge i_mclk);
		for (int a = 5'h15; a < 5'h1D; a++) rc(5'(a));
		chk_syn();
		for (int r = 0; r < 8; r++) begin
			d = $urandom;
			d[22:20] = 3'(r);
			wm(5'h16, d);
			wm(5'h17, ~d);
			wm(5'h18, d);
			wm(5'h1A, d);
			wm(5'h1B, {d[7:0], d[23:8]});
			wm(5'h19, d);
			wm(5'h1C, d);
			host.cmd(r[0] ? 8'h85 : 8'h84);
			aux_sel = r[0];
			chk_syn();
			for (int a = 5'h15; a < 5'h1D; a++) rc(5'(a));
		end
		wm(5'h1A, 24'h0000FF);
		i_rx_end = 1'b1;
		@(posedge i_mclk);
		#1;
		i_rx_end = 1'b0;
		m[26] = 24'h000000;
		m[27] = 24'h000000;
		chk_syn();
		for (int k = 0; k < 8; k++) begin
			if (k == 0 || k == 4) wm(5'h1A, k == 4 ? 24'h40 : 24'h00);
			{i_header_evt, i_second_byte_evt, i_err3_evt, i_rx_done_evt} =
				4'b1000 >> k[1:0];
			@(posedge i_mclk);
			#1;
			{i_header_evt, i_second_byte_evt, i_err3_evt, i_rx_done_evt} = 4'h0;
			chk({o_irq_header, o_third_error_interrupt}, k[2] ?
				{k[1:0] == 1, k[1:0] == 3} : {k[1:0] == 0, k[1:0] == 2});
		end
		for (int s = 0; s < 5; s++) begin
			lv = '{8'h00, 8'($urandom), 8'($urandom), 8'($urandom)};
			i_meas_select = 3'(s);
			i_mixer_a_level = lv[1];
			i_mixer_b_level = lv[2];
			i_ext_conv_level = lv[3];
			host.cmd(8'h87);
			chk(o_conv_busy, 1'b1);
			host.wait_conv();
			chk(o_conv_busy, 1'b0);
			m[25] = {16'h0000, lv[s < 4 ? s : 0]};
			rc(5'h19);
		end
		i_rx_active = 1'b1;
		push(17);
		rc(5'h1C);
		push(1);
		rc(5'h1C);
		push(6);
		rc(5'h1C);
		push(1);
		rc(5'h1C);
		i_rx_active = 1'b0;
		i_tx_active = 1'b1;
		drain(6);
		rc(5'h1C);
		drain(0);
		rc(5'h1C);
		host.cmd(8'h8F);
		ovf = 1'b0;
		rc(5'h1C);
		wm(5'h16, 24'h123456);
		wm(5'h18, 24'h00005A);
		push(3);
		i_en = 1'b0;
		repeat (6) @(posedge i_mclk);
		#1;
		i_en = 1'b1;
		repeat (6) @(posedge i_mclk);
		preset();
		host.cmd(8'h84);
		chk_syn();
		rc(5'h16);
		rc(5'h17);
		rc(5'h1C);
		complete_run();
	end
endmodule
